// [cpsr_pkg.sv]
`default_nettype none
// ==========================================================================
// shared constants and types for the codec power and status registers
package cpsr_pkg;

    // ======================================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_CHANNEL_ENABLE     = 8'h76;
    localparam logic [7:0] IDX_POWER_CONTROL      = 8'h78;
    localparam logic [7:0] IDX_CHANNEL_POWER      = 8'h79;
    localparam logic [7:0] IDX_DEVICE_MODE        = 8'h7a;
    localparam logic [7:0] IDX_IRQ_STATUS         = 8'h80;
    localparam logic [7:0] IDX_IRQ_MASK           = 8'h81;

    // ======================================================================
    // values after reset
    localparam logic [7:0] POWER_CONTROL_RESET    = 8'h00;
    localparam logic [7:0] CHANNEL_ENABLE_RESET   = 8'hcc;
    localparam logic [7:0] CHANNEL_POWER_RESET    = 8'h00;
    localparam logic [7:0] DEVICE_MODE_RESET      = 8'h80;
    localparam logic [7:0] IRQ_STATUS_RESET       = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET         = 8'h00;

    // ======================================================================
    // field layout helpers
    localparam logic [7:0] POWER_CONTROL_WMASK    = 8'hee;
    localparam int unsigned NUM_CHANNELS          = 4;
    localparam int unsigned IRQ_BITS              = 4;

    // ======================================================================
    // device mode codes
    localparam logic [2:0] MODE_SLEEP             = 3'h4;
    localparam logic [2:0] MODE_ACTIVE_IDLE       = 3'h6;
    localparam logic [2:0] MODE_ACTIVE_RUN        = 3'h7;

    // ======================================================================
    // interrupt status bit positions
    localparam int unsigned IRQ_INPUT_FAULT       = 0;
    localparam int unsigned IRQ_BIAS_FAULT        = 1;
    localparam int unsigned IRQ_MODE_CHANGE       = 2;
    localparam int unsigned IRQ_LOOP_CHANGE       = 3;

    // ======================================================================
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ          = 2'h2;
    localparam logic [2:0] HSIZE_WORD             = 3'h2;
    localparam logic [1:0] HRESP_OKAY             = 2'h0;

    // power control register layout
    typedef struct packed {
        logic record_power_up;
        logic playback_power_up;
        logic mic_bias_power_up;
        logic rsvd4;
        logic ultrasound_detect_enable;
        logic voice_detect_enable;
        logic ultrasound_aux_enable;
        logic rsvd0;
    } cpsr_power_control_type;

    // per-channel powered state, record channels 1..4 then playback 1..4
    typedef struct packed {
        logic [3:0] record_powered;
        logic [3:0] playback_powered;
    } cpsr_chan_status_type;

    // device mode register layout
    typedef struct packed {
        logic [2:0] device_mode_code;
        logic       loop_enabled_flag;
        logic       mic_bias_enabled_flag;
        logic       rsvd2;
        logic       input_fault_shutdown_flag;
        logic       bias_fault_shutdown_flag;
    } cpsr_mode_state_type;

endpackage
`default_nettype wire

// [cpsr_chan_gate.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// per-channel power gate for one path (record or playback)
module cpsr_chan_gate
    import cpsr_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // control
    input  wire logic                    path_power,
    input  wire logic [NUM_CHANNELS-1:0] chan_enable,
    input  wire logic [NUM_CHANNELS-1:0] fault_down,
    // state
    output logic      [NUM_CHANNELS-1:0] powered_r
);

    // ======================================================================
    // one flop per channel: on only when path powered, enabled, no fault
    genvar i;
    generate
        for (i = 0; i < NUM_CHANNELS; i++)
        begin : g_chan
            always_ff @(posedge clk)
            begin
                if (!rstn)
                    powered_r[i] <= 1'b0;
                else
                    powered_r[i] <= path_power & chan_enable[i] & ~fault_down[i];
            end
        end
    endgenerate

endmodule // cpsr_chan_gate
`default_nettype wire

// [cpsr_regs.sv]
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
module cpsr_regs
    import cpsr_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic [1:0]                   hresp,
    output logic [31:0]                  hrdata,
    // device condition inputs
    input  wire logic                    device_asleep,
    input  wire logic                    loop_enabled,
    input  wire logic [NUM_CHANNELS-1:0] input_fault,
    input  wire logic                    bias_fault,
    // power and algorithm controls
    output logic                         record_power_up,
    output logic                         playback_power_up,
    output logic                         mic_bias_power_up,
    output logic                         ultrasound_detect_enable,
    output logic                         voice_detect_enable,
    output logic                         ultrasound_aux_enable,
    output logic [NUM_CHANNELS-1:0]      record_ch_powered,
    output logic [NUM_CHANNELS-1:0]      playback_ch_powered,
    // interrupt
    output logic                         irq
);

    // ======================================================================
    // declarations
    cpsr_power_control_type  power_control_r;
    logic [7:0]              channel_enable_r;
    cpsr_chan_status_type    chan_status;
    cpsr_mode_state_type     mode_state_r;
    cpsr_mode_state_type     mode_state_nxt;
    logic [IRQ_BITS-1:0]     irq_status_r;
    logic [IRQ_BITS-1:0]     irq_mask_r;
    logic [IRQ_BITS-1:0]     irq_event;
    logic                    dph_valid_r;
    logic                    dph_write_r;
    logic [7:0]              dph_idx_r;
    logic                    rd_wait_r;
    logic [31:0]             hrdata_r;
    logic [7:0]              rdata_nxt;
    logic                    addr_take;
    logic                    addr_ok;
    logic                    wr_fire;
    logic [7:0]              wr_byte;
    logic [NUM_CHANNELS-1:0] rec_fault_down;
    logic                    any_chan_on;

    // ======================================================================
    // bus address phase
    // a transfer is taken when selected, nonseq and the bus is ready
    assign addr_take = hsel & (htrans == HTRANS_NONSEQ) & hready;

    // aligned word accesses inside the low window only
    assign addr_ok = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0)
                   & (hsize == HSIZE_WORD);

    // data phase tracking
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            dph_valid_r <= 1'b0;
            dph_write_r <= 1'b0;
            dph_idx_r   <= 8'h00;
        end
        else if (addr_take)
        begin
            dph_valid_r <= addr_ok;
            dph_write_r <= hwrite;
            dph_idx_r   <= haddr[9:2];
        end
        else if (hreadyout)
        begin
            dph_valid_r <= 1'b0;
            dph_write_r <= 1'b0;
        end
    end

    // reads get one wait state so a preceding write is already visible
    always_ff @(posedge clk)
    begin
        if (!rstn)
            rd_wait_r <= 1'b0;
        else
            rd_wait_r <= addr_take & ~hwrite;
    end

    assign hreadyout = ~rd_wait_r;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_r;

    // ======================================================================
    // write strobe, applied at the end of the write data phase
    assign wr_fire = dph_valid_r & dph_write_r;
    assign wr_byte = hwdata[7:0];

    // power control register; reserved bits never store
    always_ff @(posedge clk)
    begin
        if (!rstn)
            power_control_r <= POWER_CONTROL_RESET;
        else if (wr_fire && dph_idx_r == IDX_POWER_CONTROL)
            power_control_r <= wr_byte & POWER_CONTROL_WMASK;
    end

    // per-channel enables, record in the high nibble
    always_ff @(posedge clk)
    begin
        if (!rstn)
            channel_enable_r <= CHANNEL_ENABLE_RESET;
        else if (wr_fire && dph_idx_r == IDX_CHANNEL_ENABLE)
            channel_enable_r <= wr_byte;
    end

    // interrupt mask
    always_ff @(posedge clk)
    begin
        if (!rstn)
            irq_mask_r <= IRQ_MASK_RESET[IRQ_BITS-1:0];
        else if (wr_fire && dph_idx_r == IDX_IRQ_MASK)
            irq_mask_r <= wr_byte[IRQ_BITS-1:0];
    end

    // ======================================================================
    // control outputs straight from the power control register
    assign record_power_up          = power_control_r.record_power_up;
    assign playback_power_up        = power_control_r.playback_power_up;
    assign mic_bias_power_up        = power_control_r.mic_bias_power_up;
    assign ultrasound_detect_enable = power_control_r.ultrasound_detect_enable;
    assign voice_detect_enable      = power_control_r.voice_detect_enable;
    assign ultrasound_aux_enable    = power_control_r.ultrasound_aux_enable;

    // ======================================================================
    // channel power gates
    // a bias fault drops every record channel, an input fault only its own
    assign rec_fault_down = input_fault | {NUM_CHANNELS{bias_fault}};

    // record path, channel 1 in bit 3 to match the status layout
    cpsr_chan_gate u_record_gate
    (
        .clk         (clk),
        .rstn        (rstn),
        .path_power  (power_control_r.record_power_up),
        .chan_enable (channel_enable_r[7:4]),
        .fault_down  (rec_fault_down),
        .powered_r   (chan_status.record_powered)
    );

    // playback path has no fault shutdown
    cpsr_chan_gate u_playback_gate
    (
        .clk         (clk),
        .rstn        (rstn),
        .path_power  (power_control_r.playback_power_up),
        .chan_enable (channel_enable_r[3:0]),
        .fault_down  ({NUM_CHANNELS{1'b0}}),
        .powered_r   (chan_status.playback_powered)
    );

    assign record_ch_powered   = chan_status.record_powered;
    assign playback_ch_powered = chan_status.playback_powered;

    // ======================================================================
    // device mode status
    assign any_chan_on = |chan_status;

    // next mode state from live conditions
    always_comb
    begin
        mode_state_nxt = DEVICE_MODE_RESET;
        if (device_asleep)
            mode_state_nxt.device_mode_code = MODE_SLEEP;
        else if (any_chan_on)
            mode_state_nxt.device_mode_code = MODE_ACTIVE_RUN;
        else
            mode_state_nxt.device_mode_code = MODE_ACTIVE_IDLE;
        mode_state_nxt.loop_enabled_flag = loop_enabled;
        mode_state_nxt.mic_bias_enabled_flag =
            power_control_r.mic_bias_power_up & ~bias_fault;
        mode_state_nxt.rsvd2 = 1'b0;
        mode_state_nxt.input_fault_shutdown_flag = power_control_r.record_power_up
            & |(channel_enable_r[7:4] & input_fault);
        mode_state_nxt.bias_fault_shutdown_flag =
            power_control_r.record_power_up & bias_fault;
    end

    // status register; bus writes never touch it
    always_ff @(posedge clk)
    begin
        if (!rstn)
            mode_state_r <= DEVICE_MODE_RESET;
        else
            mode_state_r <= mode_state_nxt;
    end

    // ======================================================================
    // interrupt events: rising fault flags, mode or loop changes
    assign irq_event[IRQ_INPUT_FAULT] = mode_state_nxt.input_fault_shutdown_flag
                                      & ~mode_state_r.input_fault_shutdown_flag;
    assign irq_event[IRQ_BIAS_FAULT]  = mode_state_nxt.bias_fault_shutdown_flag
                                      & ~mode_state_r.bias_fault_shutdown_flag;
    assign irq_event[IRQ_MODE_CHANGE] = mode_state_nxt.device_mode_code
                                     != mode_state_r.device_mode_code;
    assign irq_event[IRQ_LOOP_CHANGE] = mode_state_nxt.loop_enabled_flag
                                     ^ mode_state_r.loop_enabled_flag;

    // sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge clk)
    begin
        if (!rstn)
            irq_status_r <= IRQ_STATUS_RESET[IRQ_BITS-1:0];
        else if (wr_fire && dph_idx_r == IDX_IRQ_STATUS)
            irq_status_r <= (irq_status_r & ~wr_byte[IRQ_BITS-1:0]) | irq_event;
        else
            irq_status_r <= irq_status_r | irq_event;
    end

    // level interrupt while any unmasked bit is set
    assign irq = |(irq_status_r & irq_mask_r);

    // ======================================================================
    // read mux, unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (dph_valid_r)
        begin
            unique case (dph_idx_r)
                IDX_POWER_CONTROL:  rdata_nxt = power_control_r & POWER_CONTROL_WMASK;
                IDX_CHANNEL_ENABLE: rdata_nxt = channel_enable_r;
                IDX_CHANNEL_POWER:  rdata_nxt = chan_status;
                IDX_DEVICE_MODE:    rdata_nxt = mode_state_r;
                IDX_IRQ_STATUS:     rdata_nxt = {4'h0, irq_status_r};
                IDX_IRQ_MASK:       rdata_nxt = {4'h0, irq_mask_r};
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data captured during the wait state, held until the next read
    always_ff @(posedge clk)
    begin
        if (!rstn)
            hrdata_r <= 32'h00000000;
        else if (rd_wait_r)
            hrdata_r <= {24'h000000, rdata_nxt};
    end

endmodule // cpsr_regs
`default_nettype wire

// [cpsr_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port-level checks of the power and status register block
module cpsr_regs_checker
    import cpsr_pkg::*;
(
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rstn,
    // bus
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic                    hready,
    input wire logic                    hreadyout,
    input wire logic [1:0]              hresp,
    input wire logic [31:0]             hrdata,
    // device side
    input wire logic [NUM_CHANNELS-1:0] input_fault,
    input wire logic                    bias_fault,
    input wire logic                    record_power_up,
    input wire logic                    playback_power_up,
    input wire logic                    mic_bias_power_up,
    input wire logic                    ultrasound_detect_enable,
    input wire logic                    voice_detect_enable,
    input wire logic                    ultrasound_aux_enable,
    input wire logic [NUM_CHANNELS-1:0] record_ch_powered,
    input wire logic [NUM_CHANNELS-1:0] playback_ch_powered,
    input wire logic                    irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // transfers taken in the address phase
    logic       rd_go;
    logic       wr_go;
    logic [5:0] ctrl;
    assign rd_go = hsel && htrans == HTRANS_NONSEQ && hready && !hwrite;
    assign wr_go = hsel && htrans == HTRANS_NONSEQ && hready && hwrite;
    assign ctrl  = {record_power_up, playback_power_up, mic_bias_power_up,
                    ultrasound_detect_enable, voice_detect_enable, ultrasound_aux_enable};

    a_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    a_read_wait: assert property (rd_go && haddr < 32'h400 |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (wr_go |=> hreadyout)
        else $error("write stalled");
    a_record_gate: assert property (
        (record_ch_powered & $past(input_fault | {4{bias_fault}})) == 4'h0
        && (record_ch_powered == 4'h0 || $past(record_power_up)))
        else $error("record channel powered while gated off");
    a_record_off: assert property (!record_power_up |=> record_ch_powered == 4'h0)
        else $error("record channel stays powered");
    a_playback_off: assert property (!playback_power_up |=> playback_ch_powered == 4'h0)
        else $error("playback channel stays powered");
    a_reserved_zero: assert property (
        rd_go && haddr == 32'h1e0 |-> ##2 (hrdata[4] == 1'b0 && hrdata[0] == 1'b0
        && hrdata[31:8] == 24'h0))
        else $error("reserved control bits read nonzero");
    a_mode_code: assert property (
        rd_go && haddr == 32'h1e8 |-> ##2 (hrdata[7:5] inside {3'h4, 3'h6, 3'h7}
        && hrdata[2] == 1'b0))
        else $error("reserved mode code reported");
    a_status_write_kept: assert property (
        wr_go && (haddr == 32'h1e4 || haddr == 32'h1e8) |=> ##1 $stable(ctrl))
        else $error("status write changed controls");
    a_ctrl_by_write: assert property (!$past(wr_go, 2) |-> $stable(ctrl))
        else $error("control changed without a write");

    // main scenarios
    c_read: cover property (rd_go);
    c_write: cover property (wr_go);
    c_irq: cover property (irq);
    c_both_paths: cover property (record_ch_powered != 4'h0 && playback_ch_powered != 4'h0);
endmodule // cpsr_regs_checker

bind cpsr_regs cpsr_regs_checker i_checker (.*);
`default_nettype wire

// [cpsr_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// self-checking bench of the power and status register block
module cpsr_regs_bench
    import cpsr_pkg::*;
;
    // one ordinary case: inputs, then expected register reads
    typedef struct packed {
        logic [7:0] pc;
        logic [7:0] en;
        logic [3:0] flt;
        logic       bf;
        logic       slp;
        logic       pll;
        logic [7:0] e_pc;
        logic [7:0] e_s0;
        logic [7:0] e_s1;
    } cpsr_row_type;

    localparam logic [31:0] A_EN = {22'h0, IDX_CHANNEL_ENABLE, 2'h0};
    localparam logic [31:0] A_PC = {22'h0, IDX_POWER_CONTROL, 2'h0};
    localparam logic [31:0] A_S0 = {22'h0, IDX_CHANNEL_POWER, 2'h0};
    localparam logic [31:0] A_S1 = {22'h0, IDX_DEVICE_MODE, 2'h0};
    localparam logic [31:0] A_IS = {22'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] A_IM = {22'h0, IDX_IRQ_MASK, 2'h0};

    // ======================================================================
    // stimulus and observed signals
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic        device_asleep = 1'b1;
    logic        loop_enabled = 1'b0;
    logic [3:0]  input_fault = 4'h0;
    logic        bias_fault = 1'b0;
    logic [31:0] rd;
    wire logic   hready;
    wire logic   hreadyout;
    wire logic   irq;
    wire logic   record_power_up;
    wire logic   playback_power_up;
    wire logic   mic_bias_power_up;
    wire logic   ultrasound_detect_enable;
    wire logic   voice_detect_enable;
    wire logic   ultrasound_aux_enable;
    wire logic [1:0]  hresp;
    wire logic [31:0] hrdata;
    wire logic [3:0]  record_ch_powered;
    wire logic [3:0]  playback_ch_powered;
    int          n_errors = 0;
    int          checks = 0;

    // ordinary cases
    cpsr_row_type rows [6] = '{
        '{8'hee, 8'hcc, 4'h0, 1'b0, 1'b0, 1'b1, 8'hee, 8'hcc, 8'hf8},
        '{8'h00, 8'hff, 4'h0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'hc0},
        '{8'h80, 8'hf0, 4'h4, 1'b0, 1'b0, 1'b0, 8'h80, 8'hb0, 8'he2},
        '{8'ha0, 8'hf3, 4'h0, 1'b1, 1'b0, 1'b1, 8'ha0, 8'h00, 8'hd1},
        '{8'h40, 8'h05, 4'h0, 1'b0, 1'b1, 1'b0, 8'h40, 8'h05, 8'h80},
        '{8'h2e, 8'h00, 4'h0, 1'b0, 1'b0, 1'b0, 8'h2e, 8'h00, 8'hc8}};

    // single bus master, ready fed back from the one slave
    assign hready = hreadyout;
    cpsr_regs i_dut (.*);

    always #20 clk = ~clk;

    // ======================================================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer; returns at the edge that ends its data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= a;
        // address phase stands until ready is seen high at a rising edge
        do
            @(posedge clk);
        while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        // data phase stands until ready again; read data taken at that edge
        do
            @(posedge clk);
        while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask

    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, {24'h0, e});
    endtask

    task automatic irq_chk(input logic e);
        @(negedge clk);
        check({31'h0, irq}, {31'h0, e});
        @(posedge clk);
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        check({14'h0, hresp, record_ch_powered, playback_ch_powered,
               record_power_up, playback_power_up,
               mic_bias_power_up, ultrasound_detect_enable, voice_detect_enable,
               ultrasound_aux_enable, irq, hreadyout}, 32'h1);
        rstn <= 1'b1;
        @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial
    begin
        do_reset();
        rchk(A_PC, 8'h00);
        rchk(A_EN, 8'hcc);
        rchk(A_S0, 8'h00);
        rchk(A_S1, 8'h80);
        $display("test reset done");
        foreach (rows[i])
        begin
            device_asleep <= rows[i].slp;
            loop_enabled <= rows[i].pll;
            input_fault <= rows[i].flt;
            bias_fault <= rows[i].bf;
            wr(A_EN, rows[i].en);
            wr(A_PC, rows[i].pc);
            rchk(A_PC, rows[i].e_pc);
            rchk(A_S0, rows[i].e_s0);
            rchk(A_S1, rows[i].e_s1);
            check({24'h0, record_power_up, playback_power_up, mic_bias_power_up, 1'b0,
                   ultrasound_detect_enable, voice_detect_enable, ultrasound_aux_enable,
                   1'b0}, {24'h0, rows[i].e_pc});
            check({24'h0, record_ch_powered, playback_ch_powered}, {24'h0, rows[i].e_s0});
        end
        $display("test table done");
        // status registers ignore writes, unmapped space reads zero
        wr(A_S0, 8'hff);
        wr(A_S1, 8'hff);
        rchk(A_S0, 8'h00);
        rchk(A_S1, 8'hc8);
        rchk(32'h400, 8'h00);
        $display("test read-only done");
        // input fault raises, mask hides, write of one clears
        wr(A_EN, 8'hf0);
        wr(A_PC, 8'h80);
        wr(A_IS, 8'h0f);
        wr(A_IM, 8'h01);
        irq_chk(1'b0);
        input_fault <= 4'h8;
        repeat (4) @(posedge clk);
        irq_chk(1'b1);
        bus(1'b0, A_IS, 32'h0);
        check(rd & 32'h1, 32'h1);
        wr(A_IM, 8'h00);
        irq_chk(1'b0);
        wr(A_IM, 8'h01);
        irq_chk(1'b1);
        wr(A_IS, 8'h01);
        irq_chk(1'b0);
        $display("test interrupt done");
        do_reset();
        rchk(A_PC, 8'h00);
        rchk(A_IM, 8'h00);
        $display("test second reset done");
        print_verdict();
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule // cpsr_regs_bench
`default_nettype wire
